/* logic/rtb_regs.sv */
// receiver-2 trim and transmitter bias calibration register bank
//
// Contract
// - gain trim counts 0.125% steps, max 15.875%
// - offset word bit 7: 0 adds, 1 subtracts
// - offset magnitude counts 0.0015% steps, max 0.1905%
// - bias multiplier codes give x1, x4, x16, x64
// - bias current equals base times multiplier
// - top four bits hold device-kept correction parity
// - bit 11 holds device-kept double-error parity
// - trims correct receiver outputs before angle calculation
`default_nettype none

module rtb_regs
    import rtb_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [RTB_ADDR_W-1:0] addr,
    input  wire logic [RTB_WORD_W-1:0] wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [RTB_WORD_W-1:0] rdata,
    output rtb_trim_type               trim,
    output logic                       load_done
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    // unpacked so that each word may have its own always_ff
    logic [RTB_DATA_W-1:0]                word_data [RTB_WORDS];
    logic [RTB_ECC_W-1:0]                 word_ecc [RTB_WORDS];
    logic                                 word_ded [RTB_WORDS];
    logic [RTB_WORDS-1:0][RTB_ECC_W-1:0]  next_ecc;
    logic [RTB_WORDS-1:0]                 next_ded;
    logic [RTB_WORDS-1:0]                 load_wr;
    logic [RTB_WORDS-1:0]                 sw_wr;
    logic                                 hit_valid;
    logic [RTB_IDX_W-1:0]                 hit_idx;
    rtb_load_state_type                   load_state;
    logic [1:0]                           load_idx;
    rtb_trim_type                         next_trim;
    logic [RTB_WORD_W-1:0]                next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    always_comb
    begin
        hit_valid = 1'b0;
        hit_idx   = '0;
        for (int i = 0; i < RTB_WORDS; i++)
        begin
            if (addr == RTB_ADDR[i])
            begin
                hit_valid = 1'b1;
                hit_idx   = RTB_IDX_W'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // startup load from store into shadow

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_state <= RTB_LOAD_ST;
            load_idx   <= 2'h0;
            load_done  <= 1'b0;
        end
        else
        begin
            case (load_state)
                RTB_LOAD_ST:
                begin
                    load_idx <= load_idx + 2'h1;
                    if (load_idx == 2'(RTB_NV_CNT - 1))
                    begin
                        load_state <= RTB_RUN_ST;
                        load_done  <= 1'b1;
                    end
                end
                RTB_RUN_ST:
                begin
                    load_state <= RTB_RUN_ST;
                end
                default:
                begin
                    load_state <= RTB_LOAD_ST;
                    load_idx   <= 2'h0;
                    load_done  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage words with device-kept parity

    generate
        for (genvar g = 0; g < RTB_WORDS; g++)
        begin : g_word
            // copy source kept in range for the store words, which never load
            localparam int SRC_IDX = (g >= RTB_NV_CNT) ? g - RTB_NV_CNT : g;
            // the load owns the shadow while it runs; software writes then are dropped
            if (g >= RTB_NV_CNT)
            begin : g_sh
                assign load_wr[g] = (load_state == RTB_LOAD_ST)
                                    && (load_idx == 2'(g - RTB_NV_CNT));
                assign sw_wr[g]   = wr && hit_valid && (hit_idx == RTB_IDX_W'(g))
                                    && (load_state == RTB_RUN_ST);
            end
            else
            begin : g_nv
                assign load_wr[g] = 1'b0;
                assign sw_wr[g]   = wr && hit_valid && (hit_idx == RTB_IDX_W'(g));
            end

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    word_data[g] <= RTB_RST[g];
                end
                else if (load_wr[g])
                begin
                    word_data[g] <= word_data[SRC_IDX];
                end
                else if (sw_wr[g])
                begin
                    // read-only bits keep their value, parity bits are never taken
                    word_data[g] <= (word_data[g] & ~RTB_WMASK[g])
                                    | (wdata[RTB_DATA_W-1:0] & RTB_WMASK[g]);
                end
            end

            rtb_ecc u_ecc (
                .data (word_data[g]),
                .ecc  (next_ecc[g]),
                .ded  (next_ded[g])
            );

            // parity follows the data one cycle later
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    word_ecc[g] <= '0;
                    word_ded[g] <= 1'b0;
                end
                else
                begin
                    word_ecc[g] <= next_ecc[g];
                    word_ded[g] <= next_ded[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read port: data valid only in the cycle after the strobe

    always_comb
    begin
        next_rdata = '0;
        if (rd)
        begin
            if (hit_valid)
            begin
                // parity fields have no software access and read as zero
                next_rdata = {5'h00, word_data[hit_idx]};
            end
            else if (addr == RTB_STATUS_ADDR)
            begin
                next_rdata[RTB_STAT_DONE_BIT] = load_done;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trim settings driven from the working copy

    always_comb
    begin
        logic [RTB_DATA_W-1:0] gain_w;
        logic [RTB_DATA_W-1:0] off_w;
        logic [RTB_DATA_W-1:0] bias_w;
        gain_w = word_data[RTB_GAIN_SH_IDX];
        off_w  = word_data[RTB_OFFSET_SH_IDX];
        bias_w = word_data[RTB_BIAS_SH_IDX];
        next_trim.gain        = gain_w[RTB_GAIN_LSB +: RTB_GAIN_W];
        next_trim.offset_sub  = off_w[RTB_OFF_SUB_BIT];
        next_trim.offset_mag  = off_w[RTB_OFF_MAG_LSB +: RTB_OFF_MAG_W];
        next_trim.bias_mult   = bias_w[RTB_BIAS_MULT_LSB +: RTB_BIAS_MULT_W];
        // factor is four to the power of the code
        next_trim.bias_factor = RTB_BIAS_FACT_W'(1) << {next_trim.bias_mult, 1'b0};
        next_trim.bias_base   = bias_w[RTB_BIAS_BASE_LSB +: RTB_BIAS_BASE_W];
        next_trim.bias_halfua = RTB_BIAS_CUR_W'(next_trim.bias_base)
                                * RTB_BIAS_CUR_W'(next_trim.bias_factor);
    end

    // zero only in reset; follows the shadow every cycle, also while the load runs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trim <= '0;
        end
        else
        begin
            trim <= next_trim;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    gain_trim_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (wr && load_done && addr == RTB_ADDR[RTB_GAIN_SH_IDX])
        |-> ##2 (trim.gain == $past(wdata[6:0], 2)))
    else $error("gain trim does not follow shadow write");

    offset_sign_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (wr && load_done && addr == RTB_ADDR[RTB_OFFSET_SH_IDX])
        |-> ##2 (trim.offset_sub == $past(wdata[7], 2)))
    else $error("offset polarity does not follow bit 7");

    offset_mag_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (wr && load_done && addr == RTB_ADDR[RTB_OFFSET_SH_IDX])
        |-> ##2 (trim.offset_mag == $past(wdata[6:0], 2)))
    else $error("offset magnitude does not follow shadow write");

    bias_mult_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        load_done |->
        ((trim.bias_mult == 2'h0 && trim.bias_factor == 7'h01)
        || (trim.bias_mult == 2'h1 && trim.bias_factor == 7'h04)
        || (trim.bias_mult == 2'h2 && trim.bias_factor == 7'h10)
        || (trim.bias_mult == 2'h3 && trim.bias_factor == 7'h40)))
    else $error("bias multiplier decode wrong");

    bias_current_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        trim.bias_halfua == RTB_BIAS_CUR_W'(trim.bias_base)
            * RTB_BIAS_CUR_W'(trim.bias_factor))
    else $error("bias current is not base times factor");

    parity_hidden_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        rd |=> (rdata[15:12] == 4'h0))
    else $error("correction parity visible to software");

    ded_hidden_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        rd |=> (rdata[11] == 1'b0))
    else $error("double-error parity visible to software");

    ded_kept_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        $stable(word_data[RTB_BIAS_SH_IDX]) |-> (word_ded[RTB_BIAS_SH_IDX]
            == ^{word_data[RTB_BIAS_SH_IDX], word_ecc[RTB_BIAS_SH_IDX]}))
    else $error("double-error parity not maintained");

    startup_load_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        $rose(load_done) |-> ##1 (trim.bias_base == word_data[RTB_BIAS_NV_IDX][5:0]
            && trim.gain == word_data[RTB_GAIN_NV_IDX][6:0]))
    else $error("shadow not loaded from store at startup");

    load_bound_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> ##[0:3] load_done)
    else $error("startup load took too long");

    read_pulse_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        !rd |=> (rdata == 16'h0000))
    else $error("read data present without a read strobe");

    shadow_copy_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (load_state == RTB_LOAD_ST && load_idx == 2'h0)
        |=> (word_data[RTB_GAIN_SH_IDX] == $past(word_data[RTB_GAIN_NV_IDX])))
    else $error("gain shadow not copied from store");

    early_drop_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == RTB_ADDR[RTB_GAIN_SH_IDX] && load_state == RTB_LOAD_ST
            && load_idx != 2'h0)
        |=> (word_data[RTB_GAIN_SH_IDX] == $past(word_data[RTB_GAIN_SH_IDX])))
    else $error("shadow write taken during startup load");

    gain_ro_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        sw_wr[RTB_GAIN_SH_IDX]
        |=> (word_data[RTB_GAIN_SH_IDX][10:7] == $past(word_data[RTB_GAIN_SH_IDX][10:7])))
    else $error("read-only gain shadow bits changed");

    store_write_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (wr && addr == RTB_ADDR[RTB_OFFSET_NV_IDX])
        |=> (word_data[RTB_OFFSET_NV_IDX] == $past(wdata[RTB_DATA_W-1:0])))
    else $error("store write did not land");

    status_read_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (rd && addr == RTB_STATUS_ADDR)
        |=> (rdata == {15'h0000, $past(load_done)}))
    else $error("status read does not show load done");

    unmapped_read_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (rd && !hit_valid && addr != RTB_STATUS_ADDR)
        |=> (rdata == 16'h0000))
    else $error("unmapped read returned data");

endmodule : rtb_regs

`default_nettype wire

/* logic/rtb_pkg.sv */
// constants, tables and types for the receiver-2 trim and transmitter bias register bank
`default_nettype none

package rtb_pkg;

    localparam int RTB_WORDS   = 6;
    localparam int RTB_ADDR_W  = 8;
    localparam int RTB_WORD_W  = 16;
    localparam int RTB_DATA_W  = 11;
    localparam int RTB_ECC_W   = 4;
    localparam int RTB_IDX_W   = 3;
    localparam int RTB_NV_CNT  = 3;

    // field positions
    localparam int RTB_ECC_LSB       = 12;
    localparam int RTB_DED_BIT       = 11;
    localparam int RTB_GAIN_LSB      = 0;
    localparam int RTB_GAIN_W        = 7;
    localparam int RTB_OFF_MAG_LSB   = 0;
    localparam int RTB_OFF_MAG_W     = 7;
    localparam int RTB_OFF_SUB_BIT   = 7;
    localparam int RTB_BIAS_BASE_LSB = 0;
    localparam int RTB_BIAS_BASE_W   = 6;
    localparam int RTB_BIAS_MULT_LSB = 6;
    localparam int RTB_BIAS_MULT_W   = 2;
    localparam int RTB_BIAS_FACT_W   = 7;
    localparam int RTB_BIAS_CUR_W    = 12;

    // word indices: nonvolatile_store first, then volatile_shadow
    localparam logic [RTB_IDX_W-1:0] RTB_GAIN_NV_IDX     = 3'h0;
    localparam logic [RTB_IDX_W-1:0] RTB_OFFSET_NV_IDX   = 3'h1;
    localparam logic [RTB_IDX_W-1:0] RTB_BIAS_NV_IDX     = 3'h2;
    localparam logic [RTB_IDX_W-1:0] RTB_GAIN_SH_IDX     = 3'h3;
    localparam logic [RTB_IDX_W-1:0] RTB_OFFSET_SH_IDX   = 3'h4;
    localparam logic [RTB_IDX_W-1:0] RTB_BIAS_SH_IDX     = 3'h5;

    // register offsets, index 5 first
    localparam logic [RTB_WORDS-1:0][RTB_ADDR_W-1:0] RTB_ADDR = {
        8'h47, 8'h46, 8'h45, 8'h07, 8'h06, 8'h05
    };
    localparam logic [RTB_ADDR_W-1:0] RTB_STATUS_ADDR = 8'h7f;
    localparam int RTB_STAT_DONE_BIT = 0;

    // software-writable bits of each word
    localparam logic [RTB_WORDS-1:0][RTB_DATA_W-1:0] RTB_WMASK = {
        11'h0ff, 11'h0ff, 11'h07f, 11'h7ff, 11'h7ff, 11'h7ff
    };

    // reset values: store defaults, shadow cleared
    localparam logic [RTB_WORDS-1:0][RTB_DATA_W-1:0] RTB_RST = {
        11'h000, 11'h000, 11'h000, 11'h0be, 11'h000, 11'h000
    };

    typedef enum logic [0:0] {
        RTB_LOAD_ST,
        RTB_RUN_ST
    } rtb_load_state_type;

    typedef struct packed {
        logic [RTB_GAIN_W-1:0]      gain;
        logic                       offset_sub;
        logic [RTB_OFF_MAG_W-1:0]   offset_mag;
        logic [RTB_BIAS_MULT_W-1:0] bias_mult;
        logic [RTB_BIAS_FACT_W-1:0] bias_factor;
        logic [RTB_BIAS_BASE_W-1:0] bias_base;
        logic [RTB_BIAS_CUR_W-1:0]  bias_halfua;
    } rtb_trim_type;

endpackage : rtb_pkg

`default_nettype wire

/* logic/rtb_ecc.sv */
// error-correction parity and double-error parity for one calibration word
`default_nettype none

module rtb_ecc
    import rtb_pkg::*;
(
    input  wire logic [RTB_DATA_W-1:0] data,
    output logic      [RTB_ECC_W-1:0]  ecc,
    output logic                       ded
);

    // hamming 15,11: data bits fill the non-power-of-two positions
    always_comb
    begin
        logic [15:1] code;
        int          k;
        code = '0;
        k    = 0;
        ecc  = '0;
        for (int p = 1; p < 16; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                code[p] = data[k];
                k       = k + 1;
            end
        end
        for (int b = 0; b < RTB_ECC_W; b++)
        begin
            for (int p = 1; p < 16; p++)
            begin
                if (((p >> b) & 1) == 1)
                begin
                    ecc[b] = ecc[b] ^ code[p];
                end
            end
        end
        ded = ^{data, ecc};
    end

endmodule : rtb_ecc

`default_nettype wire

/* tb/test_receiver2_trim_and_tx_bias_regs.sv */
// self-checking bench for the receiver-2 trim and transmitter bias register bank
`default_nettype none

module test_receiver2_trim_and_tx_bias_regs
    import rtb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  clk;
    logic                  rst_n;
    logic [RTB_ADDR_W-1:0] addr;
    logic [RTB_WORD_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
    logic [RTB_WORD_W-1:0] rdata;
    rtb_trim_type          trim;
    logic                  load_done;
    int                    errors;
    int                    total_checks;
    int                    cycles;
    logic [RTB_DATA_W-1:0] sh [3];

    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [15:0] d;
        logic [15:0] e;
    } rtb_row_type;

    // plain accesses; expected read-back beside each
    localparam rtb_row_type ROWS [15] = '{
        '{1'b0, 8'h07, 16'h0000, 16'h00be},
        '{1'b0, 8'h47, 16'h0000, 16'h00be},
        '{1'b0, 8'h7f, 16'h0000, 16'h0001},
        '{1'b1, 8'h45, 16'h0055, 16'h0055},
        '{1'b1, 8'h45, 16'hffff, 16'h007f},
        '{1'b1, 8'h46, 16'h0080, 16'h0080},
        '{1'b1, 8'h46, 16'hf7ff, 16'h00ff},
        '{1'b1, 8'h46, 16'h007f, 16'h007f},
        '{1'b1, 8'h47, 16'h0001, 16'h0001},
        '{1'b1, 8'h47, 16'h007f, 16'h007f},
        '{1'b1, 8'h47, 16'h00a6, 16'h00a6},
        '{1'b1, 8'h47, 16'h0fff, 16'h00ff},
        '{1'b1, 8'h05, 16'h87ff, 16'h07ff},
        '{1'b1, 8'h30, 16'h1234, 16'h0000},
        '{1'b1, 8'h00, 16'hffff, 16'h0000}
    };

    rtb_regs dut (
        .clk       (clk),
        .rst_n     (rst_n),
        .addr      (addr),
        .wdata     (wdata),
        .wr        (wr),
        .rd        (rd),
        .rdata     (rdata),
        .trim      (trim),
        .load_done (load_done)
    );

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////////////////
    function automatic rtb_trim_type exp_trim();
        rtb_trim_type t;
        t = '0;
        t.gain = sh[0][6:0];
        t.offset_sub = sh[1][7];
        t.offset_mag = sh[1][6:0];
        t.bias_mult = sh[2][7:6];
        t.bias_factor = 7'h01 << (2 * sh[2][7:6]);
        t.bias_base = sh[2][5:0];
        t.bias_halfua = 12'(sh[2][5:0]) * 12'(t.bias_factor);
        return t;
    endfunction : exp_trim

    task automatic fail(input string what);
        errors++;
        $display("CHECK FAILED t=%0t %s", $time, what);
    endtask : fail

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
            fail($sformatf("%s got %h exp %h", what, got, exp));
    endtask : cmp_word

    task automatic cmp_flag(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp)
            fail($sformatf("%s got %b exp %b", what, got, exp));
    endtask : cmp_flag

    task automatic cmp_trim(input rtb_trim_type got, input rtb_trim_type exp, input string what);
        total_checks++;
        if (got !== exp)
            fail($sformatf("%s got %h exp %h", what, got, exp));
    endtask : cmp_trim

    // called at a rising edge; strobes stay up until the caller lowers them
    task automatic bus_op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask : bus_op

    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        bus_op(1'b1, 1'b0, a, d);
        wr <= 1'b0;
        @(posedge clk);
    endtask : write_word

    task automatic read_word(input logic [7:0] a, input logic [15:0] exp);
        bus_op(1'b0, 1'b1, a, 16'h0000);
        rd <= 1'b0;
        #1;
        cmp_word(rdata, exp, $sformatf("read %h", a));
        @(posedge clk);
    endtask : read_word

    // early set: a shadow write is issued while the startup copy is still running, and is dropped
    task automatic do_reset(input logic early);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        cmp_word(rdata, 16'h0000, "rdata in reset");
        cmp_trim(trim, '0, "trim in reset");
        cmp_flag(load_done, 1'b0, "load_done in reset");
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr <= early;
        addr <= 8'h45;
        wdata <= 16'h0033;
        @(posedge clk);
        wr <= 1'b0;
        #1 cmp_flag(load_done, 1'b0, "load_done early");
        @(posedge clk);
        #1 cmp_flag(load_done, 1'b1, "load_done at third edge");
        sh[0] = 11'h000;
        sh[1] = 11'h000;
        sh[2] = 11'h0be;
        @(posedge clk);
        #1 cmp_trim(trim, exp_trim(), "trim after startup");
        @(posedge clk);
        $display("test reset done");
    endtask : do_reset

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////////////////
    // run is under a hundred cycles; the ceiling only catches a hang
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            fail("timeout");
            close_out();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        errors = 0;
        total_checks = 0;
        cycles = 0;
        do_reset(1'b0);
        foreach (ROWS[i])
        begin
            if (ROWS[i].w)
                write_word(ROWS[i].a, ROWS[i].d);
            if (ROWS[i].w && ROWS[i].a >= 8'h45 && ROWS[i].a <= 8'h47)
                sh[ROWS[i].a - 8'h45] = ROWS[i].e[10:0];
            read_word(ROWS[i].a, ROWS[i].e);
            cmp_trim(trim, exp_trim(), "trim fields");
        end
        $display("test table done");
        // write then read with no idle cycle between
        bus_op(1'b1, 1'b0, 8'h45, 16'hf811);
        bus_op(1'b0, 1'b1, 8'h45, 16'h0000);
        rd <= 1'b0;
        #1 cmp_word(rdata, 16'h0011, "back-to-back read");
        @(posedge clk);
        #1 cmp_word(rdata, 16'h0000, "rdata after its cycle");
        sh[0] = 11'h011;
        cmp_trim(trim, exp_trim(), "trim after back-to-back");
        @(posedge clk);
        $display("test back-to-back done");
        // store change, then a mid-run reset with a shadow write during the copy
        write_word(8'h06, 16'h0042);
        read_word(8'h06, 16'h0042);
        do_reset(1'b1);
        read_word(8'h45, 16'h0000);
        read_word(8'h06, 16'h0000);
        read_word(8'h46, 16'h0000);
        $display("test second reset done");
        close_out();
    end

endmodule : test_receiver2_trim_and_tx_bias_regs

`default_nettype wire
